// ### logic/ifd_pkg.sv
// ifd_pkg.sv: constants and carrier types of the injector fault diagnostic block
// How it works
// RULE_01: dangerous failure switches off all four transistors
// RULE_02: trip events turn off low and high sides
// RULE_03: peak overtime also starts restart delay
// RULE_04: protection latch clears while control input high
// RULE_05: channel turn-on transfers flags, clears memories
// RULE_06: memory pattern decodes to short or open
// RULE_07: one shared overvoltage comparator, low means fine
// RULE_08: overvoltage checked between the two on phases
// RULE_09: filter starts at turn-off, restarts on comparator
// RULE_10: failures held in own register until read
// RULE_11: first serial clock rise clears failure register
// RULE_12: two bits per output: 11, 01, 10
// RULE_13: leading bit flags any stored failure
// RULE_14: low three bits select peak time limit
// RULE_15: upper five bits select restart delay
// RULE_16: chip select fall presents first bit
// RULE_17: output on clock rise, input on fall
// RULE_18: master holds clock low around select edges
// RULE_19: frame sends flag then bits zero to seven
// RULE_20: frame start loads failures into shift register
// RULE_21: serial output floats while select high
// RULE_22: reset or undervoltage forces safe state
// RULE_23: received code applied when select rises
// RULE_24: low side on while control input low
// RULE_25: high level on high-side output means off
package ifd_pkg;

	// clock and timing
	localparam int unsigned CLK_MHZ         = 20;
	localparam int unsigned PEAK_BASE_US    = 192;
	localparam int unsigned PEAK_STEP_US    = 32;
	localparam int unsigned RESTART_STEP_US = 2;
	localparam int unsigned OVF_TIME_US     = 10;
	localparam int unsigned OVF_CYC         = OVF_TIME_US * CLK_MHZ;

	// structure
	localparam int unsigned NCH     = 4;
	localparam int unsigned NGRP    = 2;
	localparam int unsigned CNT_W   = 16;
	localparam int unsigned WORD_W  = 8;
	localparam int unsigned FRAME_W = 9;
	localparam int unsigned CNT_BW  = 4;

	// per-output code pairs {upper, lower}
	localparam logic [1:0] CODE_NONE  = 2'h3;
	localparam logic [1:0] CODE_OPEN  = 2'h1;
	localparam logic [1:0] CODE_SHORT = 2'h2;

	// failure register carrier
	typedef struct packed {
		logic [NCH-1:0] is_short;
		logic [NCH-1:0] is_open;
	} ifd_fault_t;

	// timing code carrier: upper five bits restart, low three peak
	typedef struct packed {
		logic [4:0] restart;
		logic [2:0] peak;
	} ifd_tcode_t;

	// all asynchronous pin inputs travel together through the synchroniser
	typedef struct packed {
		logic            rst_n;
		logic            uv;
		logic [NCH-1:0]  on_n;
		logic [NCH-1:0]  oc;
		logic [NCH-1:0]  ot;
		logic [NCH-1:0]  early;
		logic [NCH-1:0]  reached;
		logic [NGRP-1:0] hsf;
		logic [NGRP-1:0] ovc;
		logic            sck;
		logic            cs_n;
		logic            sdi;
	} ifd_pins_t;

	localparam ifd_fault_t FAULT_RST = '0;
	localparam ifd_tcode_t TCODE_RST = 8'h00;
	localparam ifd_pins_t  PIN_IDLE  = '{rst_n: 1'b1, uv: 1'b0, on_n: 4'hF, oc: 4'h0,
		ot: 4'h0, early: 4'h0, reached: 4'h0, hsf: 2'h0, ovc: 2'h0, sck: 1'b0,
		cs_n: 1'b1, sdi: 1'b0};

endpackage

// ### logic/ifd_chan_diag.sv
// ifd_chan_diag.sv: per-channel problem memories, peak timer and off-state filter
module ifd_chan_diag (
	input  wire logic                      ref_clk_i,  // 20 MHz clock
	input  wire logic                      diag_rst_i, // any reset source, high
	input  wire logic                      on_i,       // channel commanded on
	input  wire logic                      other_on_i, // other channel of the bank on
	input  wire logic                      ovc_i,      // shared off overvoltage comparator
	input  wire logic                      hard_evt_i, // dangerous event pulse
	input  wire logic                      peak_hit_i, // peak current reached
	input  wire logic [ifd_pkg::CNT_W-1:0] peak_lim_i, // peak time limit in cycles
	output logic                           short_o,    // decoded short
	output logic                           open_o,     // decoded open load
	output logic                           xfer_o,     // turn-on transfer pulse
	output logic                           late_o      // peak overtime pulse
);
	localparam int unsigned CNT_W = ifd_pkg::CNT_W;

	logic             on_q_r;
	logic             ovc_q_r;
	logic             problem_mem_first_r;
	logic             problem_mem_second_r;
	logic             problem_mem_third_r;
	logic [CNT_W-1:0] peak_cnt_r;
	logic             peak_run_r;
	logic [CNT_W-1:0] ovf_cnt_r;
	logic             ovf_run_r;
	logic             ovf_again_r;
	logic             rise_on;
	logic             fall_on;
	logic             ovc_rise;
	logic             ovf_done;
	logic             ov_set;

	// edges of the command and of the comparator
	assign rise_on  = on_i & ~on_q_r;
	assign fall_on  = ~on_i & on_q_r;
	assign ovc_rise = ovc_i & ~ovc_q_r;
	assign ovf_done = ovf_run_r && (ovf_cnt_r == CNT_W'(ifd_pkg::OVF_CYC - 1));
	// RULE_07 low comparator is no failure
	assign ov_set   = ovf_done & ovc_i & ovf_again_r & ~on_i;
	assign xfer_o   = rise_on;
	assign late_o   = peak_run_r && !peak_hit_i && (peak_cnt_r == peak_lim_i);

	// edge history
	always_ff @(posedge ref_clk_i) begin
		if (diag_rst_i) begin
			on_q_r  <= 1'b0;
			ovc_q_r <= 1'b0;
		end else begin
			on_q_r  <= on_i;
			ovc_q_r <= ovc_i;
		end
	end

	// RULE_06 memory pattern decode
	always_comb begin
		short_o = problem_mem_first_r | (problem_mem_second_r & ~problem_mem_third_r);
		open_o  = ~problem_mem_first_r & problem_mem_second_r & problem_mem_third_r;
	end

	// peak timer runs from turn-on until peak reached or limit hit
	always_ff @(posedge ref_clk_i) begin
		if (diag_rst_i) begin
			peak_run_r <= 1'b0;
			peak_cnt_r <= '0;
		end else if (rise_on) begin
			peak_run_r <= 1'b1;
			peak_cnt_r <= '0;
		end else if (!on_i || peak_hit_i || late_o) begin
			peak_run_r <= 1'b0;
		end else if (peak_run_r) begin
			peak_cnt_r <= peak_cnt_r + 1'b1;
		end
	end

	// RULE_08 RULE_09 filter only between own off and other on
	always_ff @(posedge ref_clk_i) begin
		if (diag_rst_i || on_i || other_on_i) begin
			ovf_run_r   <= 1'b0;
			ovf_cnt_r   <= '0;
			ovf_again_r <= 1'b0;
		end else if (fall_on || ovc_rise) begin
			ovf_run_r   <= 1'b1;
			ovf_cnt_r   <= '0;
			ovf_again_r <= ovc_rise;
		end else if (ovf_done) begin
			ovf_run_r   <= ovc_i;
			ovf_cnt_r   <= '0;
			ovf_again_r <= 1'b1;
		end else if (ovf_run_r) begin
			ovf_cnt_r <= ovf_cnt_r + 1'b1;
		end
	end

	// RULE_05 clear after transfer, a new event wins
	always_ff @(posedge ref_clk_i) begin
		if (diag_rst_i) begin
			problem_mem_first_r  <= 1'b0;
			problem_mem_second_r <= 1'b0;
			problem_mem_third_r  <= 1'b0;
		end else begin
			problem_mem_first_r  <= hard_evt_i | (problem_mem_first_r & ~rise_on);
			problem_mem_second_r <= late_o | (problem_mem_second_r & ~rise_on);
			problem_mem_third_r  <= ov_set | (problem_mem_third_r & ~rise_on);
		end
	end

	// RULE_05 memories empty after transfer
	a_mem_clear: assert property (@(posedge ref_clk_i) disable iff (diag_rst_i) // RULE_05
		rise_on && !hard_evt_i |=> !short_o && !open_o)
		else $error("problem memories not cleared after transfer");

	// RULE_06 decode exclusive
	a_decode_excl: assert property (@(posedge ref_clk_i) disable iff (diag_rst_i) // RULE_06
		problem_mem_first_r |-> short_o && !open_o)
		else $error("first memory did not decode to short only");

endmodule

// ### logic/ifd_injector_diag.sv
// ifd_injector_diag.sv: protection shutdown, failure register and serial fault link
module ifd_injector_diag #(
	parameter int unsigned CYC_PER_US = ifd_pkg::CLK_MHZ // clock cycles per microsecond
) (
	input  wire logic                     ref_clk_i,             // 20 MHz clock
	input  wire logic                     sys_rst_i,             // sync reset, high
	input  wire logic                     reset_pin_n_i,         // reset pin, low
	input  wire logic                     undervoltage_i,        // supply low, high
	input  wire logic [ifd_pkg::NCH-1:0]  channel_on_n_i,        // channel command, low on
	input  wire logic [ifd_pkg::NCH-1:0]  overcurrent_i,         // low side overcurrent
	input  wire logic [ifd_pkg::NCH-1:0]  overtemp_i,            // low side overtemperature
	input  wire logic [ifd_pkg::NCH-1:0]  peak_early_i,          // peak reached too early
	input  wire logic [ifd_pkg::NCH-1:0]  peak_reached_i,        // peak current comparator
	input  wire logic [ifd_pkg::NGRP-1:0] high_side_fault_in_i,  // high side fault per group
	input  wire logic [ifd_pkg::NGRP-1:0] off_overvoltage_cmp_i, // off overvoltage per group
	input  wire logic [ifd_pkg::NGRP-1:0] hs_req_a_i,            // current control wants a on
	input  wire logic [ifd_pkg::NGRP-1:0] hs_req_b_i,            // current control wants b on
	input  wire logic                     spi_clk_i,             // serial clock pin
	input  wire logic                     chip_select_n_i,       // chip select, low
	input  wire logic                     sdi_i,                 // serial data in
	output logic      [ifd_pkg::NCH-1:0]  lowside_on_o,          // low side gate, high on
	output logic      [ifd_pkg::NGRP-1:0] hs_drive_a_n_o,        // high side a, high off
	output logic      [ifd_pkg::NGRP-1:0] hs_drive_b_n_o,        // high side b, high off
	output logic                          sdo_o,                 // serial data out
	output logic                          sdo_oe_n_o             // sdo enable, low drives
);
	localparam int unsigned NCH     = ifd_pkg::NCH;
	localparam int unsigned NGRP    = ifd_pkg::NGRP;
	localparam int unsigned CNT_W   = ifd_pkg::CNT_W;
	localparam int unsigned WORD_W  = ifd_pkg::WORD_W;
	localparam int unsigned FRAME_W = ifd_pkg::FRAME_W;
	localparam int unsigned CNT_BW  = ifd_pkg::CNT_BW;

	// synchronised pins and their one-cycle history
	ifd_pkg::ifd_pins_t pin_raw;
	ifd_pkg::ifd_pins_t pin_m_r;
	ifd_pkg::ifd_pins_t pin_s_r;
	ifd_pkg::ifd_pins_t pin_q_r;
	logic               diag_rst;

	// channel side
	logic [NCH-1:0]  on_lvl;
	logic [NCH-1:0]  hard_evt;
	logic [NCH-1:0]  ch_short;
	logic [NCH-1:0]  ch_open;
	logic [NCH-1:0]  ch_xfer;
	logic [NCH-1:0]  ch_late;
	logic [NCH-1:0]  prot_r;
	logic [NCH-1:0]  prot_nxt;
	logic [NCH-1:0]  lowside_nxt;
	logic [NGRP-1:0] hsf_rise;
	logic [NGRP-1:0] grp_trip;
	logic [NGRP-1:0] grp_late;
	logic [NGRP-1:0] grp_off;
	logic [NGRP-1:0] hs_a_nxt;
	logic [NGRP-1:0] hs_b_nxt;
	logic [CNT_W-1:0] rs_cnt_r [NGRP];
	logic [CNT_W-1:0] rs_cnt_nxt [NGRP];
	logic [CNT_W-1:0] peak_lim;
	logic [CNT_W-1:0] rs_load;

	// failure register and serial side
	ifd_pkg::ifd_fault_t fault_r;
	ifd_pkg::ifd_fault_t fault_nxt;
	ifd_pkg::ifd_tcode_t timing_code_word_r;
	logic [WORD_W-1:0]  fault_status_word;
	logic [FRAME_W-1:0] tx_load;
	logic [FRAME_W-1:0] tx_r;
	logic [WORD_W-1:0]  rx_r;
	logic [CNT_BW-1:0]  bit_cnt_r;
	logic               first_rise_r;
	logic               any_fault_flag;
	logic               fault_reg_clear;
	logic               sck_rise;
	logic               sck_fall;
	logic               cs_fall;
	logic               cs_rise;
	logic               in_frame;

	// gather every pin into one carrier for the synchroniser
	assign pin_raw = '{rst_n: reset_pin_n_i, uv: undervoltage_i, on_n: channel_on_n_i,
		oc: overcurrent_i, ot: overtemp_i, early: peak_early_i, reached: peak_reached_i,
		hsf: high_side_fault_in_i, ovc: off_overvoltage_cmp_i, sck: spi_clk_i,
		cs_n: chip_select_n_i, sdi: sdi_i};

	// two-stage synchroniser; only the second stage is read by logic
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			pin_m_r <= ifd_pkg::PIN_IDLE;
			pin_s_r <= ifd_pkg::PIN_IDLE;
		end else begin
			pin_m_r <= pin_raw;
			pin_s_r <= pin_m_r;
		end
	end

	// history for edge detection, taken from the second stage
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			pin_q_r <= ifd_pkg::PIN_IDLE;
		end else begin
			pin_q_r <= pin_s_r;
		end
	end

	// RULE_22 any reset source clears all diagnostics
	assign diag_rst = sys_rst_i | ~pin_s_r.rst_n | pin_s_r.uv;

	// RULE_24 on while the active-low command is low
	assign on_lvl   = ~pin_s_r.on_n;
	assign hsf_rise = pin_s_r.hsf & ~pin_q_r.hsf;

	// RULE_14 peak limit from the low three bits
	assign peak_lim = CNT_W'((ifd_pkg::PEAK_BASE_US
		+ ifd_pkg::PEAK_STEP_US * timing_code_word_r.peak) * CYC_PER_US);
	// RULE_15 restart delay from the upper five bits
	assign rs_load  = CNT_W'(ifd_pkg::RESTART_STEP_US
		* timing_code_word_r.restart * CYC_PER_US);

	// per-channel diagnosis, protection latch and failure register bits
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		localparam int unsigned G = c / 2;

		// RULE_02 overcurrent, overtemperature, early peak, high side edge
		assign hard_evt[c] = pin_s_r.oc[c] | pin_s_r.ot[c] | pin_s_r.early[c]
			| hsf_rise[G];

		ifd_chan_diag u_diag (
			.ref_clk_i  (ref_clk_i),
			.diag_rst_i (diag_rst),
			.on_i       (on_lvl[c]),
			.other_on_i (on_lvl[c ^ 1]),
			.ovc_i      (pin_s_r.ovc[G]),
			.hard_evt_i (hard_evt[c]),
			.peak_hit_i (pin_s_r.reached[c]),
			.peak_lim_i (peak_lim),
			.short_o    (ch_short[c]),
			.open_o     (ch_open[c]),
			.xfer_o     (ch_xfer[c]),
			.late_o     (ch_late[c])
		);

		// RULE_04 latch clears while the command input is high
		assign prot_nxt[c] = grp_trip[G] | (prot_r[c] & ~pin_s_r.on_n[c]);

		// RULE_01 whole bank off when any latch of the group holds
		assign lowside_nxt[c] = ~diag_rst & on_lvl[c] & ~grp_off[G];

		// RULE_05 RULE_10 transfer at turn-on, set beats the read clear
		assign fault_nxt.is_short[c] = (ch_xfer[c] & ch_short[c])
			| (fault_r.is_short[c] & ~fault_reg_clear);
		assign fault_nxt.is_open[c]  = (ch_xfer[c] & ch_open[c])
			| (fault_r.is_open[c] & ~fault_reg_clear);

		// RULE_12 short wins over open load in the code pair
		assign fault_status_word[2*c+1:2*c] = fault_r.is_short[c] ? ifd_pkg::CODE_SHORT
			: fault_r.is_open[c] ? ifd_pkg::CODE_OPEN : ifd_pkg::CODE_NONE;
	end

	// per-group trip, restart delay and high side drive
	for (genvar g = 0; g < NGRP; g++) begin : g_grp
		// RULE_01 RULE_02 any dangerous event of either bank channel
		assign grp_trip[g] = |{hard_evt[2*g+1:2*g], ch_late[2*g+1:2*g]};
		assign grp_late[g] = |ch_late[2*g+1:2*g];
		assign grp_off[g]  = grp_trip[g] | (|prot_r[2*g+1:2*g]) | (rs_cnt_r[g] != '0);

		// RULE_03 overtime also loads the restart delay
		assign rs_cnt_nxt[g] = diag_rst ? '0 : grp_late[g] ? rs_load
			: (rs_cnt_r[g] != '0) ? rs_cnt_r[g] - 1'b1 : '0;

		// RULE_25 high level keeps the external switch off
		assign hs_a_nxt[g] = diag_rst | grp_off[g] | ~hs_req_a_i[g];
		assign hs_b_nxt[g] = diag_rst | grp_off[g] | ~hs_req_b_i[g];
	end

	// protection latches
	always_ff @(posedge ref_clk_i) begin
		if (diag_rst) begin
			prot_r <= '0;
		end else begin
			prot_r <= prot_nxt;
		end
	end

	// restart delay counters; a code of zero means no wait
	always_ff @(posedge ref_clk_i) begin
		rs_cnt_r <= rs_cnt_nxt;
	end

	// RULE_22 power stage outputs, safe during any reset
	always_ff @(posedge ref_clk_i) begin
		lowside_on_o   <= lowside_nxt;
		hs_drive_a_n_o <= hs_a_nxt;
		hs_drive_b_n_o <= hs_b_nxt;
	end

	// RULE_10 failure register, separate from the shift register
	always_ff @(posedge ref_clk_i) begin
		if (diag_rst) begin
			fault_r <= ifd_pkg::FAULT_RST;
		end else begin
			fault_r <= fault_nxt;
		end
	end

	// RULE_13 leading bit flags any stored failure
	assign any_fault_flag = |{fault_r.is_short, fault_r.is_open};

	// RULE_19 flag first, then bit 0 through bit 7
	assign tx_load[FRAME_W-1] = any_fault_flag;
	for (genvar k = 0; k < WORD_W; k++) begin : g_bit
		assign tx_load[WORD_W-1-k] = fault_status_word[k];
	end

	// RULE_18 edges are trusted because the clock is low at select changes
	assign sck_rise = pin_s_r.sck & ~pin_q_r.sck;
	assign sck_fall = ~pin_s_r.sck & pin_q_r.sck;
	assign cs_fall  = ~pin_s_r.cs_n & pin_q_r.cs_n;
	assign cs_rise  = pin_s_r.cs_n & ~pin_q_r.cs_n;
	assign in_frame = ~pin_s_r.cs_n;

	// RULE_11 clear pulse on the first clock rise of a frame
	assign fault_reg_clear = sck_rise & in_frame & first_rise_r;

	// first-rise tracker
	always_ff @(posedge ref_clk_i) begin
		if (diag_rst) begin
			first_rise_r <= 1'b0;
		end else if (cs_fall) begin
			first_rise_r <= 1'b1;
		end else if (sck_rise) begin
			first_rise_r <= 1'b0;
		end
	end

	// RULE_16 RULE_20 load at select fall, first bit out at once
	// RULE_17 later bits move out on each clock rise
	always_ff @(posedge ref_clk_i) begin
		if (diag_rst) begin
			tx_r  <= '0;
			sdo_o <= 1'b0;
		end else if (cs_fall) begin
			tx_r  <= tx_load;
			sdo_o <= tx_load[FRAME_W-1];
		end else if (sck_rise && in_frame) begin
			tx_r  <= {tx_r[FRAME_W-2:0], 1'b0};
			sdo_o <= tx_r[FRAME_W-2];
		end
	end

	// RULE_21 float while select high
	always_ff @(posedge ref_clk_i) begin
		sdo_oe_n_o <= diag_rst | pin_s_r.cs_n;
	end

	// RULE_17 capture on each clock fall; keeps the last eight bits
	always_ff @(posedge ref_clk_i) begin
		if (diag_rst) begin
			rx_r      <= '0;
			bit_cnt_r <= '0;
		end else if (cs_fall) begin
			bit_cnt_r <= '0;
		end else if (sck_fall && in_frame) begin
			rx_r <= {pin_s_r.sdi, rx_r[WORD_W-1:1]};
			if (bit_cnt_r != CNT_BW'(WORD_W)) begin
				bit_cnt_r <= bit_cnt_r + 1'b1;
			end
		end
	end

	// RULE_23 short frames leave the timing code untouched
	always_ff @(posedge ref_clk_i) begin
		if (diag_rst) begin
			timing_code_word_r <= ifd_pkg::TCODE_RST;
		end else if (cs_rise && bit_cnt_r == CNT_BW'(WORD_W)) begin
			timing_code_word_r <= ifd_pkg::ifd_tcode_t'(rx_r);
		end
	end

	default clocking dc @(posedge ref_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	// RULE_11 register empty after clear
	a_fault_clear: assert property (fault_reg_clear && !(|ch_xfer) && !diag_rst // RULE_11
		|=> fault_r == ifd_pkg::FAULT_RST)
		else $error("failure register not cleared by first clock rise");

	// RULE_16 first bit is the flag
	a_first_bit: assert property (cs_fall && !diag_rst // RULE_16
		|=> sdo_o == $past(any_fault_flag))
		else $error("sdo does not show the any-fault flag after select fall");

	// RULE_17 shift on clock rise
	a_shift_out: assert property (sck_rise && in_frame && !cs_fall && !diag_rst // RULE_17
		|=> sdo_o == $past(tx_r[FRAME_W-2]))
		else $error("sdo did not advance on clock rise");

	// RULE_21 floating output
	a_sdo_float: assert property (pin_s_r.cs_n |=> sdo_oe_n_o) // RULE_21
		else $error("sdo driven while select high");

	// RULE_02 group shut down
	a_trip_off: assert property (grp_trip[0] // RULE_02
		|=> lowside_on_o[1:0] == 2'h0 && hs_drive_a_n_o[0] && hs_drive_b_n_o[0])
		else $error("group not shut down after trip");

	// RULE_22 safe state under reset
	a_reset_safe: assert property (diag_rst // RULE_22
		|=> lowside_on_o == '0 && (&hs_drive_a_n_o) && (&hs_drive_b_n_o) && sdo_oe_n_o)
		else $error("outputs not safe during reset");

	// RULE_03 delay loaded on overtime
	a_restart_load: assert property (grp_late[0] && !diag_rst // RULE_03
		|=> rs_cnt_r[0] == $past(rs_load))
		else $error("restart delay not started on peak overtime");

	// RULE_04 latch release
	a_prot_clear: assert property (pin_s_r.on_n[0] && !grp_trip[0] |=> !prot_r[0]) // RULE_04
		else $error("protection latch held while input high");

	// RULE_12 code for a short
	a_word_code: assert property (fault_r.is_short[0] // RULE_12
		|-> fault_status_word[1:0] == ifd_pkg::CODE_SHORT)
		else $error("short not coded as 1,0");

	// RULE_23 code applied at select rise
	a_code_apply: assert property (cs_rise && bit_cnt_r == CNT_BW'(WORD_W) && !diag_rst // RULE_23
		|=> timing_code_word_r == $past(rx_r))
		else $error("timing code not applied at select rise");

	// RULE_24 low side stays off while its command is high
	a_ls_cmd_off: assert property (!on_lvl[0] |=> !lowside_on_o[0]) // RULE_24
		else $error("low side on while its command input is high");

	// RULE_03 running restart delay keeps the bank off
	a_restart_hold: assert property (rs_cnt_r[0] != '0 |=> lowside_on_o[1:0] == 2'h0) // RULE_03
		else $error("low side on while the restart delay runs");

	// RULE_01 second group shuts all four switches together
	a_trip_off_b: assert property (grp_trip[1] // RULE_01
		|=> lowside_on_o[3:2] == 2'h0 && hs_drive_a_n_o[1] && hs_drive_b_n_o[1])
		else $error("second group not shut down after trip");

	// RULE_19 bit 0 follows the flag in the loaded frame
	a_d0_next: assert property (cs_fall && !diag_rst // RULE_19
		|=> tx_r[FRAME_W-2] == $past(fault_status_word[0]))
		else $error("bit 0 does not follow the flag");

endmodule

// ### bench/ifd_spi_master.sv
// ifd_spi_master.sv: serial master that reads the fault word and writes the timing code
module ifd_spi_master (
	input  wire logic sdo_i,      // serial data from device
	input  wire logic sdo_oe_n_i, // device drives when low
	output logic      sck_o,      // serial clock
	output logic      cs_n_o,     // chip select, low
	output logic      sdi_o       // serial data to device
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		sdi_o = 1'b0;
	end
	// nine clock periods of 400 ns, 200 ns high; odd start offset keeps the link phase unrelated
	task automatic xfer(input logic [7:0] code, output logic en_n, output logic [8:0] rx);
		logic [8:0] tx;
		tx = {code, ~code[0]};
		#137 cs_n_o = 1'b0;
		#400 rx[0] = sdo_i;
		en_n = sdo_oe_n_i;
		// drive on rise, sample before fall
		for (int k = 0; k < 9; k++) begin
			sck_o = 1'b1;
			sdi_o = tx[k];
			#200 if (k < 8) rx[k+1] = sdo_i;
			sck_o = 1'b0;
			#200;
		end
		cs_n_o = 1'b1;
		// a released line must not keep its last level
		sdi_o = ~sdi_o;
	endtask
endmodule

// ### bench/test_injector_fault_diag_spi.sv
// test_injector_fault_diag_spi.sv: self-checking bench of the injector fault block
module test_injector_fault_diag_spi;
	timeunit 1ns;
	timeprecision 1ns;
	logic       ref_clk;
	logic       sys_rst;
	logic       rst_pin_n;
	logic       uv;
	logic [3:0] chan_n;
	logic [3:0] oc;
	logic [3:0] pk;
	logic [3:0] ot;
	logic [3:0] early;
	logic [1:0] hsf;
	logic [1:0] ovc;
	logic [1:0] hs_req;
	logic [3:0] ls_on;
	logic [1:0] hs_a_n;
	logic [1:0] hs_b_n;
	logic       sdo;
	logic       sdo_oe_n;
	logic       sck;
	logic       cs_n;
	logic       sdi;
	wire logic  sdo_w;
	int         failures = 0;
	int         n_tests = 0;
	int         cycles = 0;

	// a floating line reads as z so a missing drive never matches
	assign sdo_w = sdo_oe_n ? 1'bz : sdo;
	// one cycle per microsecond keeps peak and restart counts short
	ifd_injector_diag #(.CYC_PER_US(1)) dut (
		.ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .reset_pin_n_i(rst_pin_n),
		.undervoltage_i(uv), .channel_on_n_i(chan_n), .overcurrent_i(oc),
		.overtemp_i(ot), .peak_early_i(early), .peak_reached_i(pk),
		.high_side_fault_in_i(hsf), .off_overvoltage_cmp_i(ovc),
		.hs_req_a_i(hs_req), .hs_req_b_i(hs_req), .spi_clk_i(sck),
		.chip_select_n_i(cs_n), .sdi_i(sdi), .lowside_on_o(ls_on),
		.hs_drive_a_n_o(hs_a_n), .hs_drive_b_n_o(hs_b_n), .sdo_o(sdo),
		.sdo_oe_n_o(sdo_oe_n)
	);
	ifd_spi_master mst (
		.sdo_i(sdo_w), .sdo_oe_n_i(sdo_oe_n), .sck_o(sck), .cs_n_o(cs_n), .sdi_o(sdi)
	);
	// 20 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// wait edges, then step past them so outputs are settled
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	// one serial frame with expected flag and fault word
	task automatic frame(input logic [7:0] code, input logic eflag, input logic [7:0] eword);
		logic       en_n;
		logic [8:0] rx;
		mst.xfer(code, en_n, rx);
		check({6'h00, en_n, rx[0]}, {7'h00, eflag});
		check(rx[8:1], eword);
		cyc(6);
		check({7'h00, sdo_oe_n}, 8'h01);
	endtask
	task automatic complete_run();
		$display("counts: %0d compares, %0d mismatches", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// hang guard, ceiling well above the under two thousand cycles the tests need
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 10000) begin
			failures++;
			$display("mismatch at %0t: run timed out", $time);
			complete_run();
		end
	end
	initial begin
		sys_rst = 1'b1;
		rst_pin_n = 1'b1;
		uv = 1'b0;
		chan_n = 4'hF;
		oc = 4'h0;
		ot = 4'h0;
		early = 4'h0;
		pk = 4'hF;
		hsf = 2'h0;
		ovc = 2'h0;
		hs_req = 2'h3;
		cyc(2);
		check({ls_on, hs_a_n, hs_b_n}, 8'h0F);
		sys_rst <= 1'b0;
		cyc(6);
		$display("test reset done");
		// trips in both groups, then transfer on the next turn-on
		chan_n <= 4'hA;
		cyc(6);
		check({4'h0, ls_on}, 8'h05);
		oc <= 4'h1;
		hsf <= 2'h2;
		cyc(1);
		oc <= 4'h0;
		cyc(6);
		check({ls_on, hs_a_n, hs_b_n}, 8'h0F);
		chan_n <= 4'hF;
		cyc(6);
		chan_n <= 4'h2;
		cyc(6);
		check({4'h0, ls_on}, 8'h0D);
		chan_n <= 4'hF;
		hsf <= 2'h0;
		cyc(6);
		frame(8'h00, 1'b1, 8'hAE);
		frame(8'h00, 1'b0, 8'hFF);
		$display("test trip done");
		// peak overtime then filtered off overvoltage gives open load
		pk <= 4'hD;
		chan_n <= 4'hD;
		cyc(185);
		check({4'h0, ls_on}, 8'h02);
		cyc(20);
		check({4'h0, ls_on}, 8'h00);
		ovc <= 2'h1;
		chan_n <= 4'hF;
		cyc(500);
		ovc <= 2'h0;
		chan_n <= 4'hD;
		cyc(6);
		chan_n <= 4'hF;
		cyc(6);
		frame(8'h00, 1'b1, 8'hF7);
		$display("test open load done");
		// longest peak limit and restart delay
		frame(8'hFF, 1'b0, 8'hFF);
		pk <= 4'hE;
		chan_n <= 4'hE;
		cyc(405);
		check({4'h0, ls_on}, 8'h01);
		cyc(25);
		check({4'h0, ls_on}, 8'h00);
		chan_n <= 4'hF;
		cyc(2);
		chan_n <= 4'hE;
		cyc(28);
		check({4'h0, ls_on}, 8'h00);
		cyc(40);
		check({4'h0, ls_on}, 8'h01);
		$display("test timing code done");
		// reset pin, then undervoltage, with a short stored
		pk <= 4'hF;
		// overtemperature and early peak each trip the first group
		ot <= 4'h1;
		cyc(1);
		ot <= 4'h0;
		cyc(6);
		check({ls_on, hs_a_n, hs_b_n}, 8'h05);
		chan_n <= 4'hF;
		cyc(6);
		chan_n <= 4'hE;
		cyc(6);
		check({ls_on, hs_a_n, hs_b_n}, 8'h10);
		early <= 4'h1;
		cyc(1);
		early <= 4'h0;
		cyc(6);
		check({ls_on, hs_a_n, hs_b_n}, 8'h05);
		for (int i = 0; i < 2; i++) begin
			rst_pin_n <= (i != 0);
			uv <= (i != 0);
			cyc(6);
			check({ls_on, hs_a_n, hs_b_n}, 8'h0F);
			rst_pin_n <= 1'b1;
			uv <= 1'b0;
			cyc(6);
			check({4'h0, ls_on}, 8'h01);
		end
		chan_n <= 4'hF;
		cyc(6);
		frame(8'h00, 1'b0, 8'hFF);
		$display("test safe state done");
		complete_run();
	end
endmodule
